// ===== include/bvs_pkg.sv
// constants, types and helpers of the buck voltage select register bank
// Summary of operation
// R1 - source select bit 0 takes the code from the primary register, 1 from the alternate.
// R2 - with the strap pin low the select pin picks primary or alternate while the source bit is 0.
// R3 - alternate bit 7 turns the converter off at 0 and on at 1; its reset value is a power-up input.
// R4 - economy bit 1 gives economy mode only while the forced-pwm bit is 0.
// R5 - the six-bit codes of both voltage registers are decoded with the converter's range field.
// R6 - limit bits 7 to 6 select the output range that is reported with the code.
// R7 - a code above the ceiling field is replaced by the ceiling, on write and on output.
// R8 - a ceiling other than 0x3F or 0x00 locks range and ceiling against changes.
// R9 - reset loads every register from the one-time-programmable default inputs.
// R10 - primary bit 7 is read-only zero; software writes 0 there.
// R11 - forced-pwm bit 0 allows auto pwm/pfm switching, 1 forces pwm and kills economy.
// R12 - writes to a locked limit register are dropped and reads return the locked value.
package bvs_pkg;

    // ****************************************
    // register indices, byte address is four times the index
    // ****************************************
    localparam logic [9:0] IDX_C2_PRIM = 10'h007;
    localparam logic [9:0] IDX_C2_ALT  = 10'h008;
    localparam logic [9:0] IDX_C2_LIM  = 10'h009;
    localparam logic [9:0] IDX_C3_PRIM = 10'h00a;
    localparam logic [9:0] IDX_C3_ALT  = 10'h00b;
    localparam logic [9:0] IDX_MODE    = 10'h010;
    localparam logic [9:0] IDX_C2_STAT = 10'h011;
    localparam logic [9:0] IDX_C3_STAT = 10'h012;

    // ****************************************
    // field positions and values
    // ****************************************
    localparam int unsigned BIT_UNUSED_BIT   = 7;
    localparam int unsigned BIT_SRC    = 6;
    localparam int unsigned BIT_EN     = 7;
    localparam int unsigned BIT_ECO    = 6;
    localparam int unsigned BIT_MODE2  = 0;
    localparam int unsigned BIT_MODE3  = 1;
    localparam logic [5:0]  CEIL_OPEN  = 6'h3f;
    localparam logic [5:0]  CEIL_ZERO  = 6'h00;
    localparam logic [7:0]  MODE_RST   = 8'h00;
    localparam logic [31:0] RDATA_NONE = 32'h0000_0000;

    // ****************************************
    // types
    // ****************************************
    typedef struct packed {
        logic [7:0] prim;
        logic [7:0] alt;
        logic [7:0] lim;
    } bvs_regs_t;

    typedef struct packed {
        logic       locked;
        logic       src_alt;
        logic       en;
        logic       economy_bit;
        logic       pwm;
        logic [1:0] range;
        logic [5:0] code;
    } bvs_out_t;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [5:0] clamp_code(input logic [5:0] code,
                                              input logic [5:0] ceil);
        clamp_code = (code > ceil) ? ceil : code;
    endfunction : clamp_code

    function automatic logic is_locked(input logic [5:0] ceil);
        is_locked = (ceil != CEIL_OPEN) && (ceil != CEIL_ZERO);
    endfunction : is_locked

endpackage : bvs_pkg

// ===== design/bvs_sync.sv
// two-stage synchroniser for the external strap and select pins
`timescale 1ns/1ns
`default_nettype none
module bvs_sync
(
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [2:0] pin_in,
    output logic      [2:0] pin_out
);
    typedef struct packed {
        logic [2:0] meta;
        logic [2:0] sync;
    } bvs_sync_st_t;

    bvs_sync_st_t st_q;
    bvs_sync_st_t st_d;

    // first stage is read only by the second
    always_comb
    begin
        st_d.meta = pin_in;
        st_d.sync = st_q.meta;
        if (rst)
        begin
            st_d = '0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        st_q <= st_d;
    end

    assign pin_out = st_q.sync;
endmodule : bvs_sync
`default_nettype wire

// ===== design/bvs_conv_sel.sv
// per-converter voltage source choice, ceiling clamp and mode decode
`timescale 1ns/1ns
`default_nettype none
module bvs_conv_sel
(
    input  wire logic                 strap,
    input  wire logic                 sel_pin,
    input  wire logic                 pwm,
    input  wire bvs_pkg::bvs_regs_t   regs,
    output bvs_pkg::bvs_out_t         out
);
    logic use_alt;

    always_comb
    begin
        // R1 source select bit
        // R2 pin control with strap low
        use_alt = regs.prim[bvs_pkg::BIT_SRC] | (~strap & sel_pin);
        out.src_alt = use_alt;
        // R7 ceiling clamp on output
        out.code = bvs_pkg::clamp_code(use_alt ? regs.alt[5:0]
                                               : regs.prim[5:0],
                                       regs.lim[5:0]);
        // R5 code decoded with range
        // R6 range field
        out.range = regs.lim[7:6];
        // R3 converter enable
        out.en = regs.alt[bvs_pkg::BIT_EN];
        // R4 economy gated by forced pwm
        // R11 forced pwm mode
        out.economy_bit = regs.alt[bvs_pkg::BIT_ECO] & ~pwm;
        out.pwm = pwm;
        // R8 lock detection
        out.locked = bvs_pkg::is_locked(regs.lim[5:0]);
    end
endmodule : bvs_conv_sel
`default_nettype wire

// ===== design/bvs_top.sv
// apb register bank for the voltage selection of converters 2 and 3
`timescale 1ns/1ns
`default_nettype none
module bvs_top
(
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    input  wire logic [11:0]          paddr,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 config_strap_pin,
    input  wire logic                 conv2_select_pin,
    input  wire logic                 conv3_select_pin,
    input  wire bvs_pkg::bvs_regs_t   otp_conv2,
    input  wire bvs_pkg::bvs_regs_t   otp_conv3,
    input  wire logic [1:0]           otp_pwm_force,
    output bvs_pkg::bvs_out_t         conv2_out,
    output bvs_pkg::bvs_out_t         conv3_out
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        bvs_pkg::bvs_regs_t c2;
        bvs_pkg::bvs_regs_t c3;
        logic [7:0]         mode;
        logic [31:0]        rdata;
        logic               ready;
        logic               slverr;
        bvs_pkg::bvs_out_t  o2;
        bvs_pkg::bvs_out_t  o3;
    } bvs_st_t;

    bvs_st_t           st_q;
    bvs_st_t           st_d;
    logic [2:0]        pins;
    bvs_pkg::bvs_out_t sel2;
    bvs_pkg::bvs_out_t sel3;
    logic [9:0]        idx;
    logic              mapped;
    logic              wr_go;
    logic              setup;

    // ****************************************
    // pins and converter decode
    // ****************************************
    // pins arrive from outside, so they pass two flops first
    bvs_sync u_sync
    (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pin_in  ({conv3_select_pin, conv2_select_pin, config_strap_pin}),
        .pin_out (pins)
    );

    bvs_conv_sel u_sel2
    (
        .strap   (pins[0]),
        .sel_pin (pins[1]),
        .pwm     (st_q.mode[bvs_pkg::BIT_MODE2]),
        .regs    (st_q.c2),
        .out     (sel2)
    );

    bvs_conv_sel u_sel3
    (
        .strap   (pins[0]),
        .sel_pin (pins[2]),
        .pwm     (st_q.mode[bvs_pkg::BIT_MODE3]),
        .regs    (st_q.c3),
        .out     (sel3)
    );

    // ****************************************
    // apb decode
    // ****************************************
    assign idx    = paddr[11:2];
    assign setup  = psel & ~penable & ~st_q.ready;
    assign wr_go  = psel & penable & st_q.ready & pwrite & ~st_q.slverr;
    assign mapped = (paddr[1:0] == 2'b00) &&
                    ((idx == bvs_pkg::IDX_C2_PRIM) ||
                     (idx == bvs_pkg::IDX_C2_ALT)  ||
                     (idx == bvs_pkg::IDX_C2_LIM)  ||
                     (idx == bvs_pkg::IDX_C3_PRIM) ||
                     (idx == bvs_pkg::IDX_C3_ALT)  ||
                     (idx == bvs_pkg::IDX_MODE)    ||
                     (idx == bvs_pkg::IDX_C2_STAT) ||
                     (idx == bvs_pkg::IDX_C3_STAT));

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        st_d = st_q;
        st_d.o2 = sel2;
        st_d.o3 = sel3;
        // answer one cycle after setup, so pready is always a flop
        st_d.ready = setup;
        st_d.slverr = setup & ~mapped;
        if (setup)
        begin
            st_d.rdata = bvs_pkg::RDATA_NONE;
            case (idx)
                bvs_pkg::IDX_C2_PRIM: st_d.rdata[7:0] = st_q.c2.prim;
                bvs_pkg::IDX_C2_ALT:  st_d.rdata[7:0] = st_q.c2.alt;
                // R12 locked values read back
                bvs_pkg::IDX_C2_LIM:  st_d.rdata[7:0] = st_q.c2.lim;
                bvs_pkg::IDX_C3_PRIM: st_d.rdata[7:0] = st_q.c3.prim;
                bvs_pkg::IDX_C3_ALT:  st_d.rdata[7:0] = st_q.c3.alt;
                bvs_pkg::IDX_MODE:    st_d.rdata[7:0] = st_q.mode;
                bvs_pkg::IDX_C2_STAT:
                    st_d.rdata[7:0] = {sel2.locked, sel2.src_alt,
                                       sel2.code};
                bvs_pkg::IDX_C3_STAT:
                    st_d.rdata[7:0] = {sel3.locked, sel3.src_alt,
                                       sel3.code};
                default:              st_d.rdata = bvs_pkg::RDATA_NONE;
            endcase
            // a misaligned hit on a real index still answers with zero
            if (!mapped)
            begin
                st_d.rdata = bvs_pkg::RDATA_NONE;
            end
        end
        if (wr_go)
        begin
            case (idx)
                // R10 unused bit kept zero
                // R7 clamp on write
                bvs_pkg::IDX_C2_PRIM:
                    st_d.c2.prim = {1'b0, pwdata[bvs_pkg::BIT_SRC],
                        bvs_pkg::clamp_code(pwdata[5:0], st_q.c2.lim[5:0])};
                bvs_pkg::IDX_C2_ALT:
                    st_d.c2.alt = {pwdata[7:6],
                        bvs_pkg::clamp_code(pwdata[5:0], st_q.c2.lim[5:0])};
                bvs_pkg::IDX_C2_LIM:
                begin
                    // R8 lock range and ceiling
                    // R12 locked writes dropped
                    if (!sel2.locked)
                    begin
                        st_d.c2.lim = pwdata[7:0];
                    end
                end
                bvs_pkg::IDX_C3_PRIM:
                    st_d.c3.prim = {1'b0, pwdata[bvs_pkg::BIT_SRC],
                        bvs_pkg::clamp_code(pwdata[5:0], st_q.c3.lim[5:0])};
                bvs_pkg::IDX_C3_ALT:
                    st_d.c3.alt = {pwdata[7:6],
                        bvs_pkg::clamp_code(pwdata[5:0], st_q.c3.lim[5:0])};
                bvs_pkg::IDX_MODE:
                    st_d.mode = {6'h00, pwdata[1:0]};
                default:
                    st_d.mode = st_q.mode;
            endcase
        end
        // R9 power-on defaults
        if (rst)
        begin
            st_d = '0;
            st_d.c2 = otp_conv2;
            st_d.c3 = otp_conv3;
            st_d.c2.prim[bvs_pkg::BIT_UNUSED_BIT] = 1'b0;
            st_d.c3.prim[bvs_pkg::BIT_UNUSED_BIT] = 1'b0;
            st_d.mode = bvs_pkg::MODE_RST | {6'h00, otp_pwm_force};
        end
    end

    always_ff @(posedge clk_sys)
    begin
        st_q <= st_d;
    end

    assign prdata    = st_q.rdata;
    assign pready    = st_q.ready;
    assign pslverr   = st_q.slverr;
    assign conv2_out = st_q.o2;
    assign conv3_out = st_q.o3;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    logic pw_c2p;
    logic pw_c2l;
    assign pw_c2p = wr_go && (idx == bvs_pkg::IDX_C2_PRIM);
    assign pw_c2l = wr_go && (idx == bvs_pkg::IDX_C2_LIM);

    // ****************************************
    // assertion helpers, assertions and covers
    // ****************************************
    logic pw_c2a;
    logic pw_c3p;
    logic pw_c3a;
    logic bad_go;
    assign pw_c2a = wr_go && (idx == bvs_pkg::IDX_C2_ALT);
    assign pw_c3p = wr_go && (idx == bvs_pkg::IDX_C3_PRIM);
    assign pw_c3a = wr_go && (idx == bvs_pkg::IDX_C3_ALT);
    assign bad_go = psel && penable && st_q.ready && st_q.slverr;

    a_src_primary: assert property ( // R1
        !st_q.c2.prim[bvs_pkg::BIT_SRC] && pins[0]
        |=> conv2_out.code == bvs_pkg::clamp_code($past(st_q.c2.prim[5:0]),
                                                  $past(st_q.c2.lim[5:0])))
        else $error("conv2 code not from primary");

    a_src_alternate: assert property ( // R1
        st_q.c3.prim[bvs_pkg::BIT_SRC]
        |=> conv3_out.src_alt && conv3_out.code ==
            bvs_pkg::clamp_code($past(st_q.c3.alt[5:0]),
                                $past(st_q.c3.lim[5:0])))
        else $error("conv3 code not from alternate");

    a_pin_control: assert property ( // R2
        !pins[0] && pins[1] |=> conv2_out.src_alt)
        else $error("select pin ignored while strap low");

    a_enable_follow: assert property ( // R3
        !rst |=> conv2_out.en == $past(st_q.c2.alt[bvs_pkg::BIT_EN]))
        else $error("enable does not follow bit 7");

    a_c3_enable: assert property ( // R3
        !rst |=> conv3_out.en == $past(st_q.c3.alt[bvs_pkg::BIT_EN]))
        else $error("conv3 enable wrong");

    a_eco_gating: assert property ( // R4
        !rst |=> conv3_out.economy_bit == ($past(st_q.c3.alt[bvs_pkg::BIT_ECO]) &&
                                   !$past(st_q.mode[bvs_pkg::BIT_MODE3])))
        else $error("economy mode wrong");

    a_c2_eco: assert property ( // R4
        !rst |=> conv2_out.economy_bit == ($past(st_q.c2.alt[bvs_pkg::BIT_ECO]) &&
                                   !$past(st_q.mode[bvs_pkg::BIT_MODE2])))
        else $error("conv2 economy mode wrong");

    a_range_out: assert property ( // R6
        !rst |=> conv2_out.range == $past(st_q.c2.lim[7:6]))
        else $error("range not reported");

    a_c3_range: assert property ( // R6
        !rst |=> conv3_out.range == $past(st_q.c3.lim[7:6]))
        else $error("conv3 range not reported");

    a_code_capped: assert property ( // R7
        !rst |=> conv2_out.code <= $past(st_q.c2.lim[5:0]))
        else $error("code above ceiling");

    a_c3_code_capped: assert property ( // R7
        !rst |=> conv3_out.code <= $past(st_q.c3.lim[5:0]))
        else $error("conv3 code above ceiling");

    a_write_clamp: assert property ( // R7
        pw_c2p |=> st_q.c2.prim[5:0] ==
            bvs_pkg::clamp_code($past(pwdata[5:0]), $past(st_q.c2.lim[5:0])))
        else $error("primary write not clamped");

    a_lock_hold: assert property ( // R12
        pw_c2l && bvs_pkg::is_locked(st_q.c2.lim[5:0])
        |=> $stable(st_q.c2.lim))
        else $error("locked limit changed");

    a_unlock_write: assert property ( // R8
        pw_c2l && !bvs_pkg::is_locked(st_q.c2.lim[5:0])
        |=> st_q.c2.lim == $past(pwdata[7:0]))
        else $error("unlocked limit write lost");

    a_unused_bit_zero: assert property ( // R10
        !st_q.c2.prim[bvs_pkg::BIT_UNUSED_BIT] && !st_q.c3.prim[bvs_pkg::BIT_UNUSED_BIT])
        else $error("primary bit 7 not zero");

    a_ready_pulse: assert property (
        setup |=> pready ##1 !pready)
        else $error("apb answer not one cycle");

    a_c3_src_primary: assert property ( // R1
        !st_q.c3.prim[bvs_pkg::BIT_SRC] && pins[0]
        |=> conv3_out.code == bvs_pkg::clamp_code($past(st_q.c3.prim[5:0]),
                                                  $past(st_q.c3.lim[5:0])))
        else $error("conv3 code not from primary");

    a_c2_src_alternate: assert property ( // R1
        st_q.c2.prim[bvs_pkg::BIT_SRC]
        |=> conv2_out.src_alt && conv2_out.code ==
            bvs_pkg::clamp_code($past(st_q.c2.alt[5:0]),
                                $past(st_q.c2.lim[5:0])))
        else $error("conv2 code not from alternate");

    a_c3_pin_control: assert property ( // R2
        !pins[0] && pins[2] |=> conv3_out.src_alt)
        else $error("conv3 select pin ignored");

    a_strap_ignore: assert property ( // R2
        pins[0] && !st_q.c2.prim[bvs_pkg::BIT_SRC] |=> !conv2_out.src_alt)
        else $error("select pin used while strap high");

    a_pwm_report: assert property ( // R11
        !rst |=> conv2_out.pwm == $past(st_q.mode[bvs_pkg::BIT_MODE2]) &&
                 conv3_out.pwm == $past(st_q.mode[bvs_pkg::BIT_MODE3]))
        else $error("forced pwm not reported");

    a_mode_write: assert property ( // R11
        wr_go && idx == bvs_pkg::IDX_MODE
        |=> st_q.mode == {6'h00, $past(pwdata[1:0])})
        else $error("mode write lost");

    a_lock_flag: assert property ( // R8
        !rst |=> conv2_out.locked ==
                 bvs_pkg::is_locked($past(st_q.c2.lim[5:0])))
        else $error("lock flag wrong");

    a_alt_clamp: assert property ( // R7
        pw_c2a |=> st_q.c2.alt[5:0] ==
            bvs_pkg::clamp_code($past(pwdata[5:0]), $past(st_q.c2.lim[5:0])))
        else $error("alternate write not clamped");

    a_c3_prim_clamp: assert property ( // R7
        pw_c3p |=> st_q.c3.prim[5:0] ==
            bvs_pkg::clamp_code($past(pwdata[5:0]), $past(st_q.c3.lim[5:0])))
        else $error("conv3 primary write not clamped");

    a_c3_alt_clamp: assert property ( // R7
        pw_c3a |=> st_q.c3.alt[5:0] ==
            bvs_pkg::clamp_code($past(pwdata[5:0]), $past(st_q.c3.lim[5:0])))
        else $error("conv3 alternate write not clamped");

    a_reset_load: assert property (disable iff (1'b0) // R9
        rst |=> st_q.c2.alt == $past(otp_conv2.alt) &&
                st_q.c3.lim == $past(otp_conv3.lim))
        else $error("defaults not loaded");

    a_reset_mode: assert property (disable iff (1'b0) // R9
        rst |=> st_q.mode == {6'h00, $past(otp_pwm_force)})
        else $error("mode default not loaded");

    a_bad_no_write: assert property (
        bad_go |=> $stable(st_q.c2) && $stable(st_q.c3) &&
                   $stable(st_q.mode))
        else $error("refused write changed a register");

    a_bad_rdata: assert property (
        pslverr |-> prdata == bvs_pkg::RDATA_NONE)
        else $error("refused access returned data");

    a_read_prim: assert property (
        setup && mapped && idx == bvs_pkg::IDX_C2_PRIM
        |=> prdata == {24'h00_0000, $past(st_q.c2.prim)})
        else $error("primary read data wrong");

    c_pin_alt: cover property (!pins[0] && pins[1] ##1 conv2_out.src_alt);
    c_lock_drop: cover property (pw_c2l && sel2.locked);
    c_clamped: cover property (pw_c2p && pwdata[5:0] > st_q.c2.lim[5:0]);
    c_slverr: cover property (pslverr);
    c_src_reg: cover property (st_q.c3.prim[bvs_pkg::BIT_SRC] ##1
                               conv3_out.src_alt);

endmodule : bvs_top
`default_nettype wire

// ===== tb/bvs_top_tb_top.sv
// self-checking bench of the buck voltage select register bank
`timescale 1ns/1ns
`default_nettype none
module bvs_top_tb_top;

    // ****************************************
    // signals and addresses
    // ****************************************
    logic               clk_sys;
    logic               rst;
    logic [11:0]        paddr;
    logic               psel;
    logic               penable;
    logic               pwrite;
    logic [31:0]        pwdata;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic               config_strap_pin;
    logic               conv2_select_pin;
    logic               conv3_select_pin;
    bvs_pkg::bvs_regs_t otp_conv2;
    bvs_pkg::bvs_regs_t otp_conv3;
    logic [1:0]         otp_pwm_force;
    bvs_pkg::bvs_out_t  conv2_out;
    bvs_pkg::bvs_out_t  conv3_out;
    integer             miscompares;
    integer             checks;

    localparam logic [11:0] A_C2P  = {bvs_pkg::IDX_C2_PRIM, 2'b00};
    localparam logic [11:0] A_C2A  = {bvs_pkg::IDX_C2_ALT, 2'b00};
    localparam logic [11:0] A_C2L  = {bvs_pkg::IDX_C2_LIM, 2'b00};
    localparam logic [11:0] A_C3P  = {bvs_pkg::IDX_C3_PRIM, 2'b00};
    localparam logic [11:0] A_C3A  = {bvs_pkg::IDX_C3_ALT, 2'b00};
    localparam logic [11:0] A_MODE = {bvs_pkg::IDX_MODE, 2'b00};
    localparam logic [11:0] A_C2S  = {bvs_pkg::IDX_C2_STAT, 2'b00};
    localparam logic [11:0] A_C3S  = {bvs_pkg::IDX_C3_STAT, 2'b00};

    bvs_top DUT
    (
        .clk_sys          (clk_sys),
        .rst              (rst),
        .paddr            (paddr),
        .psel             (psel),
        .penable          (penable),
        .pwrite           (pwrite),
        .pwdata           (pwdata),
        .prdata           (prdata),
        .pready           (pready),
        .pslverr          (pslverr),
        .config_strap_pin (config_strap_pin),
        .conv2_select_pin (conv2_select_pin),
        .conv3_select_pin (conv3_select_pin),
        .otp_conv2        (otp_conv2),
        .otp_conv3        (otp_conv3),
        .otp_pwm_force    (otp_pwm_force),
        .conv2_out        (conv2_out),
        .conv3_out        (conv3_out)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks = checks + 1;
        if (seen !== exp)
        begin
            miscompares = miscompares + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // apb transfer; signals move just after a rising edge, and pready,
    // prdata and pslverr are taken at the rising edge that ends the access
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [7:0] d, output logic [31:0] rd,
                       output logic err);
        integer n;
        n = 0;
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h00_0000, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            n = n + 1;
        end
        while (pready !== 1'b1 && n < 20);
        rd  = prdata;
        err = pslverr;
        if (pready !== 1'b1)
            miscompares = miscompares + 1;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, d, rd, err);
        chk({31'h0, err}, 32'h0000_0000);
    endtask : wr

    task automatic rdchk(input logic [11:0] a, input logic [7:0] exp);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 8'h00, rd, err);
        chk(rd, {24'h00_0000, exp});
        chk({31'h0, err}, 32'h0000_0000);
    endtask : rdchk

    // outputs lag registers by one edge and pins by three
    task automatic settle;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : settle

    task automatic out2(input logic [12:0] exp);
        settle();
        chk({19'h0, conv2_out}, {19'h0, exp});
    endtask : out2

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        rdchk(A_C2P, 8'h34);
        rdchk(A_C2A, 8'hbc);
        rdchk(A_C2L, 8'hbf);
        rdchk(A_C3P, 8'h36);
        rdchk(A_C3A, 8'h2c);
        rdchk(A_MODE, 8'h00);
        // {locked,src_alt,en,eco,pwm,range,code}
        out2(13'b0_0_1_0_0_10_110100);
        chk({19'h0, conv3_out}, {19'h0, 13'b0_0_0_0_0_01_110110});
        $display("test reset done");
    endtask : t_reset

    task automatic t_source;
        wr(A_C2P, 8'hd0);
        rdchk(A_C2P, 8'h50);
        out2(13'b0_1_1_0_0_10_111100);
        wr(A_C2P, 8'h10);
        out2(13'b0_0_1_0_0_10_010000);
        $display("test source done");
    endtask : t_source

    task automatic t_mode;
        wr(A_C2A, 8'h45);
        out2(13'b0_0_0_1_0_10_010000);
        wr(A_MODE, 8'h03);
        rdchk(A_MODE, 8'h03);
        out2(13'b0_0_0_0_1_10_010000);
        chk({31'h0, conv3_out.pwm}, 32'h0000_0001);
        wr(A_MODE, 8'h00);
        wr(A_C3A, 8'hc7);
        rdchk(A_C3A, 8'hc7);
        wr(A_C3P, 8'h40);
        settle();
        chk({30'h0, conv3_out.en, conv3_out.economy_bit}, 32'h0000_0003);
        chk({25'h0, conv3_out.src_alt, conv3_out.code}, 32'h0000_0047);
        wr(A_C3P, 8'h36);
        $display("test mode done");
    endtask : t_mode

    task automatic t_pins;
        @(posedge clk_sys);
        config_strap_pin <= 1'b0;
        conv2_select_pin <= 1'b1;
        out2(13'b0_1_0_1_0_10_000101);
        @(posedge clk_sys);
        conv2_select_pin <= 1'b0;
        conv3_select_pin <= 1'b1;
        out2(13'b0_0_0_1_0_10_010000);
        chk({26'h0, conv3_out.code}, 32'h0000_0007);
        rdchk(A_C3S, 8'h47);
        @(posedge clk_sys);
        config_strap_pin <= 1'b1;
        conv3_select_pin <= 1'b0;
        $display("test pins done");
    endtask : t_pins

    task automatic t_limit;
        logic [31:0] rd;
        logic        err;
        wr(A_C2L, 8'h40);
        out2(13'b0_0_0_1_0_01_000000);
        wr(A_C2P, 8'h12);
        rdchk(A_C2P, 8'h00);
        wr(A_C2L, 8'hff);
        rdchk(A_C2L, 8'hff);
        wr(A_C2L, 8'h90);
        wr(A_C2P, 8'h25);
        rdchk(A_C2P, 8'h10);
        out2(13'b1_0_0_1_0_10_010000);
        rdchk(A_C2S, 8'h90);
        wr(A_C2L, 8'h3f);
        rdchk(A_C2L, 8'h90);
        apb(1'b0, 12'h030, 8'h00, rd, err);
        chk({31'h0, err}, 32'h0000_0001);
        chk(rd, 32'h0000_0000);
        apb(1'b1, 12'h01d, 8'h7f, rd, err);
        chk({31'h0, err}, 32'h0000_0001);
        rdchk(A_C2P, 8'h10);
        $display("test limit done");
    endtask : t_limit

    task automatic t_rereset;
        @(posedge clk_sys);
        rst           <= 1'b1;
        otp_pwm_force <= 2'b01;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        rdchk(A_C2L, 8'hbf);
        rdchk(A_C2P, 8'h34);
        rdchk(A_MODE, 8'h01);
        out2(13'b0_0_1_0_1_10_110100);
        $display("test rereset done");
    endtask : t_rereset

    // ****************************************
    // run control
    // ****************************************
    task automatic summarize;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize

    initial
    begin
        miscompares      = 0;
        checks           = 0;
        rst              = 1'b1;
        paddr            = 12'h000;
        psel             = 1'b0;
        penable          = 1'b0;
        pwrite           = 1'b0;
        pwdata           = 32'h0000_0000;
        config_strap_pin = 1'b1;
        conv2_select_pin = 1'b0;
        conv3_select_pin = 1'b0;
        otp_conv2        = {8'hb4, 8'hbc, 8'hbf};
        otp_conv3        = {8'h36, 8'h2c, 8'h7f};
        otp_pwm_force    = 2'b00;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_source();
        t_mode();
        t_pins();
        t_limit();
        t_rereset();
        summarize();
    end

    // the tests need well under 1000 cycles; this cuts a hang short
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        miscompares = miscompares + 1;
        summarize();
    end

endmodule : bvs_top_tb_top
`default_nettype wire
